// file: design/random_port_access_consts.svh
`ifndef RANDOM_PORT_ACCESS_CONSTS_SVH
`define RANDOM_PORT_ACCESS_CONSTS_SVH

// ************************************************************
// Array geometry
// ************************************************************
`define RPA_WORDS            4096
`define RPA_ADDR_W           12
`define RPA_DATA_W           16
`define RPA_BYTE_W           8
`define RPA_LANES            2

// ************************************************************
// Command register space
// ************************************************************
`define RPA_CMD_ADDR_W       3
`define RPA_CMD_DATA_W       13
`define RPA_CMD_HI_W         5
`define RPA_OFS_START_ONE    3'h0
`define RPA_OFS_END_ONE      3'h1
`define RPA_OFS_START_TWO    3'h2
`define RPA_OFS_END_TWO      3'h3
`define RPA_OFS_FLAGS        3'h4
`define RPA_OFS_CONTROL      3'h5

// ************************************************************
// Field positions and reset values
// ************************************************************
`define RPA_CTRL_FLAG_ONE    0
`define RPA_CTRL_FLAG_TWO    1
`define RPA_RST_BOUND        12'h000
`define RPA_RST_CONTROL      13'h0000
`define RPA_RST_DATA         16'h0000

`endif

// file: design/random_port_access_pkg.sv
// ************************************************************
// Types shared by the random port files
// ************************************************************
package random_port_access_pkg;

    typedef struct packed {
        logic port_sel_n;
        logic reg_sel_n;
        logic read_not_write;
        logic out_drive_n;
        logic low_half_enable_n;
        logic high_half_enable_n;
    } host_ctl_t;

    typedef struct packed {
        logic [11:0] start_one;
        logic [11:0] end_one;
        logic [11:0] start_two;
        logic [11:0] end_two;
    } buffer_bounds_t;

    typedef struct packed {
        logic        en;
        logic [1:0]  lanes;
        logic [2:0]  addr;
        logic [12:0] data;
    } cmd_write_t;

    typedef enum logic [4:0] {
        ACC_IDLE     = 5'b00001,
        ACC_ARRAY_RD = 5'b00010,
        ACC_ARRAY_WR = 5'b00100,
        ACC_REG_RD   = 5'b01000,
        ACC_REG_WR   = 5'b10000
    } access_t;

endpackage

// file: design/dual_port_array.sv
`timescale 1ns/1ps
`include "random_port_access_consts.svh"

module dual_port_array #(
    parameter int WORDS  = `RPA_WORDS,
    parameter int ADDR_W = `RPA_ADDR_W,
    parameter int LANES  = `RPA_LANES
) (
    // Clock
    input  wire logic                   clock_i,
    // Random side
    input  wire logic [ADDR_W-1:0]      rnd_addr_i,
    input  wire logic [LANES-1:0]       rnd_lane_wr_i,
    input  wire logic [LANES*8-1:0]     rnd_wdata_i,
    output logic      [LANES*8-1:0]     rnd_rdata_o,
    // Sequential side
    input  wire logic                   seq_wr_i,
    input  wire logic [ADDR_W-1:0]      seq_addr_i,
    input  wire logic [LANES*8-1:0]     seq_wdata_i,
    output logic      [LANES*8-1:0]     seq_rdata_o
);

    // ************************************************************
    // One array per byte lane, random side last so it wins a collision
    // ************************************************************
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        logic [7:0] lane_mem [WORDS];

        assign rnd_rdata_o[g*8 +: 8] = lane_mem[rnd_addr_i];
        assign seq_rdata_o[g*8 +: 8] = lane_mem[seq_addr_i];

        always_ff @(posedge clock_i) begin
            if (seq_wr_i) begin
                lane_mem[seq_addr_i] <= seq_wdata_i[g*8 +: 8];
            end
            if (rnd_lane_wr_i[g]) begin
                lane_mem[rnd_addr_i] <= rnd_wdata_i[g*8 +: 8];
            end
        end
    end

endmodule

// file: design/buffer_command_regs.sv
`timescale 1ns/1ps
`include "random_port_access_consts.svh"

module buffer_command_regs (
    // Clock and reset
    input  wire logic                                  clock_i,
    input  wire logic                                  rst_n_i,
    // Register access
    input  wire random_port_access_pkg::cmd_write_t    wr_i,
    input  wire logic [`RPA_CMD_ADDR_W-1:0]            rd_addr_i,
    output logic      [`RPA_CMD_DATA_W-1:0]            rd_data_o,
    // Sequential side
    input  wire logic [1:0]                            end_hit_i,
    output random_port_access_pkg::buffer_bounds_t     bounds_o,
    output logic [1:0]                                 flags_o
);

    logic [`RPA_CMD_DATA_W-1:0] reg_words [6];
    logic [1:0]                 flags_reg;
    logic [1:0]                 flag_clear;
    logic [`RPA_CMD_DATA_W-1:0] wmask;
    logic                       ctrl_wr;

    // ************************************************************
    // Stored registers, byte lanes masked
    // ************************************************************
    assign wmask = {{`RPA_CMD_HI_W{wr_i.lanes[1]}}, {`RPA_BYTE_W{wr_i.lanes[0]}}};

    for (genvar g = 0; g < 6; g++) begin : g_reg
        if (g == 4) begin : g_flags_slot
            assign reg_words[g] = {11'h000, flags_reg};
        end else begin : g_store
            logic [`RPA_CMD_DATA_W-1:0] value_reg;

            assign reg_words[g] = value_reg;

            always_ff @(posedge clock_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    value_reg <= `RPA_RST_CONTROL;
                end else if (wr_i.en && wr_i.addr == 3'(g)) begin
                    value_reg <= (value_reg & ~wmask) | (wr_i.data & wmask);
                end
            end
        end
    end

    // ************************************************************
    // Buffer end flags: set wins over a clearing write
    // ************************************************************
    assign ctrl_wr    = wr_i.en && wr_i.lanes[0] && wr_i.addr == `RPA_OFS_CONTROL;
    assign flag_clear = {ctrl_wr && !wr_i.data[`RPA_CTRL_FLAG_TWO],
                         ctrl_wr && !wr_i.data[`RPA_CTRL_FLAG_ONE]};

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flags_reg <= 2'h0;
        end else begin
            flags_reg <= end_hit_i | (flags_reg & ~flag_clear);
        end
    end

    // ************************************************************
    // Read mux, unused offsets read zero
    // ************************************************************
    assign rd_data_o = (rd_addr_i < 3'h6) ? reg_words[rd_addr_i] : 13'h0000;
    assign flags_o   = flags_reg;
    assign bounds_o  = '{start_one: reg_words[0][11:0], end_one: reg_words[1][11:0],
                         start_two: reg_words[2][11:0], end_two: reg_words[3][11:0]};

endmodule

// file: design/random_port_access.sv
`timescale 1ns/1ps
`include "random_port_access_consts.svh"

// Summary of operation
// - 12-bit address picks one of 4096 words
// - Port active only while exactly one of port select and register select is low; port_idle_o follows port select alone
// - Deselected port never alters array contents
// - Register space uses address 0-2, data 0-12
// - Array write on low direction, read high
// - Direction chooses command register read or write
// - Data lines driven only on output drive read
// - Low enable gates data bits 0 to 7
// - High enable gates bits 8-15 independently
// - Random port served beside clocked sequential port
// - Writing zero to control bits clears flags
module random_port_access #(
    parameter int ADDR_W = `RPA_ADDR_W,
    parameter int DATA_W = `RPA_DATA_W
) (
    // Clock and reset
    input  wire logic                                  clock_i,
    input  wire logic                                  rst_n_i,
    // Random port controls and address
    input  wire random_port_access_pkg::host_ctl_t     host_ctl_i,
    input  wire logic [ADDR_W-1:0]                     word_address_lines_i,
    // Random port data pins
    input  wire logic [DATA_W-1:0]                     random_data_lines_i,
    output logic      [DATA_W-1:0]                     random_data_lines_o,
    output logic      [1:0]                            random_data_lines_oe_o,
    // Port status
    output logic                                       port_idle_o,
    output random_port_access_pkg::access_t            access_o,
    // Sequential side array access
    input  wire logic                                  seq_wr_i,
    input  wire logic [ADDR_W-1:0]                     seq_addr_i,
    input  wire logic [DATA_W-1:0]                     seq_wdata_i,
    output logic      [DATA_W-1:0]                     seq_rdata_o,
    // Sequential side buffer control
    input  wire logic [1:0]                            seq_end_hit_i,
    output random_port_access_pkg::buffer_bounds_t     bounds_o,
    output logic                                       buffer_end_flag_one_n_o,
    output logic                                       buffer_end_flag_two_n_o
);

    // ************************************************************
    // Declarations
    // ************************************************************
    random_port_access_pkg::access_t    access_reg;
    random_port_access_pkg::access_t    access_next;
    random_port_access_pkg::cmd_write_t cmd_wr;

    logic                       array_sel;
    logic                       reg_sel;
    logic                       both_sel;
    logic                       no_sel;
    logic                       rd_dir;
    logic [1:0]                 lane_on;
    logic [1:0]                 array_lane_wr;
    logic [1:0]                 drive_lanes;
    logic [DATA_W-1:0]          array_q;
    logic [`RPA_CMD_DATA_W-1:0] cmd_q;
    logic [DATA_W-1:0]          read_sel;
    logic [DATA_W-1:0]          rdata_reg;
    logic [DATA_W-1:0]          rdata_next;
    logic [1:0]                 flags;

    // ************************************************************
    // Select decode
    // ************************************************************
    assign both_sel  = !host_ctl_i.port_sel_n && !host_ctl_i.reg_sel_n;
    assign no_sel    = host_ctl_i.port_sel_n && host_ctl_i.reg_sel_n;
    assign array_sel = !host_ctl_i.port_sel_n && host_ctl_i.reg_sel_n;
    assign reg_sel   = host_ctl_i.port_sel_n && !host_ctl_i.reg_sel_n;
    assign rd_dir    = host_ctl_i.read_not_write;
    assign lane_on   = {!host_ctl_i.high_half_enable_n,
                        !host_ctl_i.low_half_enable_n};

    // ************************************************************
    // Access kind
    // ************************************************************
    always_comb begin
        access_next = random_port_access_pkg::ACC_IDLE;
        if (array_sel) begin
            access_next = rd_dir ? random_port_access_pkg::ACC_ARRAY_RD
                                 : random_port_access_pkg::ACC_ARRAY_WR;
        end else if (reg_sel) begin
            access_next = rd_dir ? random_port_access_pkg::ACC_REG_RD
                                 : random_port_access_pkg::ACC_REG_WR;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            access_reg <= random_port_access_pkg::ACC_IDLE;
        end else begin
            access_reg <= access_next;
        end
    end

    // ************************************************************
    // Array write strobes per byte lane
    // ************************************************************
    assign array_lane_wr = (array_sel && !rd_dir) ? lane_on : 2'h0;

    // ************************************************************
    // Array, random and sequential ports side by side
    // ************************************************************
    dual_port_array #(
        .WORDS  (`RPA_WORDS),
        .ADDR_W (ADDR_W),
        .LANES  (`RPA_LANES)
    ) u_array (
        .clock_i       (clock_i),
        .rnd_addr_i    (word_address_lines_i),
        .rnd_lane_wr_i (array_lane_wr),
        .rnd_wdata_i   (random_data_lines_i),
        .rnd_rdata_o   (array_q),
        .seq_wr_i      (seq_wr_i),
        .seq_addr_i    (seq_addr_i),
        .seq_wdata_i   (seq_wdata_i),
        .seq_rdata_o   (seq_rdata_o)
    );

    // ************************************************************
    // Command register write, reduced address and data
    // ************************************************************
    assign cmd_wr = '{en:    reg_sel && !rd_dir && (lane_on != 2'h0),
                      lanes: lane_on,
                      addr:  word_address_lines_i[`RPA_CMD_ADDR_W-1:0],
                      data:  random_data_lines_i[`RPA_CMD_DATA_W-1:0]};

    buffer_command_regs u_cmd (
        .clock_i   (clock_i),
        .rst_n_i   (rst_n_i),
        .wr_i      (cmd_wr),
        .rd_addr_i (word_address_lines_i[`RPA_CMD_ADDR_W-1:0]),
        .rd_data_o (cmd_q),
        .end_hit_i (seq_end_hit_i),
        .bounds_o  (bounds_o),
        .flags_o   (flags)
    );

    // ************************************************************
    // Read data capture
    // ************************************************************
    assign read_sel   = array_sel ? array_q
                                  : {{(DATA_W-`RPA_CMD_DATA_W){1'b0}}, cmd_q};
    assign rdata_next = ((array_sel || reg_sel) && rd_dir) ? read_sel : rdata_reg;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_reg <= `RPA_RST_DATA;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // ************************************************************
    // Pin drive per byte lane
    // ************************************************************
    assign drive_lanes = (!host_ctl_i.out_drive_n && rd_dir && !both_sel && !no_sel)
                         ? lane_on : 2'h0;

    assign random_data_lines_o    = rdata_reg;
    assign random_data_lines_oe_o = drive_lanes;

    // ************************************************************
    // Status and flags
    // ************************************************************
    assign port_idle_o             = host_ctl_i.port_sel_n;
    assign access_o                = access_reg;
    assign buffer_end_flag_one_n_o = !flags[0];
    assign buffer_end_flag_two_n_o = !flags[1];

endmodule

// file: tb/random_port_access_asserts.sv
`timescale 1ns/1ps
// ********
// Random port checker
// ********
module random_port_access_asserts #(
    parameter int ADDR_W = 12,
    parameter int DATA_W = 16
) (
    // Clock and reset
    input wire logic                              clock_i,
    input wire logic                              rst_n_i,
    // Host side
    input wire random_port_access_pkg::host_ctl_t host_ctl_i,
    input wire logic [ADDR_W-1:0]                 word_address_lines_i,
    input wire logic [DATA_W-1:0]                 random_data_lines_i,
    input wire logic [DATA_W-1:0]                 random_data_lines_o,
    input wire logic [1:0]                        random_data_lines_oe_o,
    input wire logic                              port_idle_o,
    input wire random_port_access_pkg::access_t   access_o,
    // Flags
    input wire logic [1:0]                        seq_end_hit_i,
    input wire logic                              buffer_end_flag_one_n_o,
    input wire logic                              buffer_end_flag_two_n_o
);
    wire psn = host_ctl_i.port_sel_n;
    wire rsn = host_ctl_i.reg_sel_n;
    wire rw  = host_ctl_i.read_not_write;
    wire lbn = host_ctl_i.low_half_enable_n;
    wire hbn = host_ctl_i.high_half_enable_n;
    wire drv = !host_ctl_i.out_drive_n && rw && (psn ^ rsn);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_arr(logic r);
        !psn && rsn && rw == r && !lbn && !hbn;
    endsequence
    sequence s_ctl_zero(int b);
        psn && !rsn && !rw && !lbn && word_address_lines_i[2:0] == 3'h5
            && !random_data_lines_i[b] && !seq_end_hit_i[b];
    endsequence
    property p_idle; port_idle_o == psn; endproperty
    property p_oe_low; random_data_lines_oe_o[0] == (drv && !lbn); endproperty
    property p_oe_high; random_data_lines_oe_o[1] == (drv && !hbn); endproperty
    property p_arr_rd; s_arr(1'b1) |=> access_o == random_port_access_pkg::ACC_ARRAY_RD; endproperty
    property p_arr_wr; s_arr(1'b0) |=> access_o == random_port_access_pkg::ACC_ARRAY_WR; endproperty
    property p_reg_rd; psn && !rsn && rw && !lbn |=> access_o == random_port_access_pkg::ACC_REG_RD;
    endproperty
    property p_reg_wr; psn && !rsn && !rw |=> access_o == random_port_access_pkg::ACC_REG_WR;
    endproperty
    property p_none;
        psn == rsn |=> access_o == random_port_access_pkg::ACC_IDLE && $stable(random_data_lines_o);
    endproperty
    property p_set_one; seq_end_hit_i[0] |=> !buffer_end_flag_one_n_o; endproperty
    property p_clr_one; s_ctl_zero(0) |=> buffer_end_flag_one_n_o; endproperty
    property p_clr_two; s_ctl_zero(1) |=> buffer_end_flag_two_n_o; endproperty
    a_idle: assert property (p_idle) else $error("idle flag wrong");
    a_oe_low: assert property (p_oe_low) else $error("low lane drive wrong");
    a_oe_high: assert property (p_oe_high) else $error("high lane drive wrong");
    a_arr_rd: assert property (p_arr_rd) else $error("array read missed");
    a_arr_wr: assert property (p_arr_wr) else $error("array write missed");
    a_reg_rd: assert property (p_reg_rd) else $error("register read missed");
    a_reg_wr: assert property (p_reg_wr) else $error("register write missed");
    a_none: assert property (p_none) else $error("access without one select");
    a_set_one: assert property (p_set_one) else $error("flag one not set");
    a_clr_one: assert property (p_clr_one) else $error("flag one not cleared");
    a_clr_two: assert property (p_clr_two) else $error("flag two not cleared");
endmodule

bind random_port_access random_port_access_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_i (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .host_ctl_i(host_ctl_i),
    .word_address_lines_i(word_address_lines_i), .random_data_lines_i(random_data_lines_i),
    .random_data_lines_o(random_data_lines_o), .random_data_lines_oe_o(random_data_lines_oe_o),
    .port_idle_o(port_idle_o), .access_o(access_o), .seq_end_hit_i(seq_end_hit_i),
    .buffer_end_flag_one_n_o(buffer_end_flag_one_n_o),
    .buffer_end_flag_two_n_o(buffer_end_flag_two_n_o));

// file: tb/host_model.sv
`timescale 1ns/1ps
// ********
// Host on the random port
// ********
module host_model (
    // Clock
    input  wire logic                         clock_i,
    // Pins
    output random_port_access_pkg::host_ctl_t ctl_o,
    output logic      [11:0]                  addr_o,
    input  wire logic [15:0]                  dev_data_i,
    input  wire logic [1:0]                   dev_oe_i,
    output logic      [15:0]                  pin_o
);
    logic        drv;
    logic [15:0] wd;
    logic [15:0] last;
    initial begin
        ctl_o = 6'h3f;
        addr_o = 12'h000;
        drv = 1'b0;
        wd = 16'h0000;
        last = 16'h0000;
    end
    // Undriven lanes show the inverse of their last level
    assign pin_o[7:0]  = dev_oe_i[0] ? dev_data_i[7:0] : drv ? wd[7:0] : ~last[7:0];
    assign pin_o[15:8] = dev_oe_i[1] ? dev_data_i[15:8] : drv ? wd[15:8] : ~last[15:8];
    always @(posedge clock_i) begin
        last <= pin_o;
    end
    // One request, held until the next edge
    task automatic go(input logic ps, input logic rs, input logic rw, input logic [1:0] ln,
                      input logic [11:0] a, input logic [15:0] d);
        @(posedge clock_i);
        ctl_o  <= {ps, rs | ~ps, rw, ~rw, ~ln[0], ~ln[1]};
        addr_o <= a;
        wd     <= d;
        drv    <= ~rw;
    endtask
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ps
// ********
// Bench
// ********
module tb_top;
    logic clock_i, rst_n_i, seq_wr, f1n, f2n;
    logic [11:0] addr, seq_addr;
    logic [15:0] pin, dout, srd, seq_wd;
    logic [1:0] oe, hit;
    random_port_access_pkg::host_ctl_t ctl;
    random_port_access_pkg::access_t acc;
    random_port_access_pkg::buffer_bounds_t bnd;
    logic [15:0] mem [4096];
    logic [15:0] exp_q [$];
    logic [11:0] adr [8];
    logic [11:0] v [4];
    int n_errors, comparisons, seed;

    random_port_access random_port_access_i (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .host_ctl_i(ctl), .word_address_lines_i(addr),
        .random_data_lines_i(pin), .random_data_lines_o(dout), .random_data_lines_oe_o(oe),
        .port_idle_o(), .access_o(acc), .seq_wr_i(seq_wr), .seq_addr_i(seq_addr),
        .seq_wdata_i(seq_wd), .seq_rdata_o(srd), .seq_end_hit_i(hit), .bounds_o(bnd),
        .buffer_end_flag_one_n_o(f1n), .buffer_end_flag_two_n_o(f2n));
    host_model host_model_i (.clock_i(clock_i), .ctl_o(ctl), .addr_o(addr),
        .dev_data_i(dout), .dev_oe_i(oe), .pin_o(pin));

    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        if (n_errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] ln);
        host_model_i.go(1'b0, 1'b1, 1'b0, ln, a, d);
        if (ln[0]) mem[a][7:0] = d[7:0];
        if (ln[1]) mem[a][15:8] = d[15:8];
    endtask
    task automatic rd(input logic [11:0] a);
        host_model_i.go(1'b0, 1'b1, 1'b1, 2'h3, a, 16'h0000);
        exp_q.push_back(mem[a]);
    endtask
    // Read pushes d as the expected value; upper address bits must be ignored
    task automatic reg_op(input logic rw, input logic [2:0] o, input logic [15:0] d);
        host_model_i.go(1'b1, 1'b0, rw, 2'h3, {9'h1a5, o}, d);
        if (rw) exp_q.push_back(d);
    endtask
    task automatic idle;
        host_model_i.go(1'b1, 1'b1, 1'b1, 2'h0, 12'h000, 16'h0000);
    endtask

    // Monitor: each read answer is matched to the oldest note
    always @(posedge clock_i) begin
        #1;
        if (acc === random_port_access_pkg::ACC_ARRAY_RD) begin
            check("array read", dout, exp_q.pop_front());
        end else if (acc === random_port_access_pkg::ACC_REG_RD) begin
            check("register read", {3'h0, dout[12:0]}, exp_q.pop_front());
        end
    end

    initial begin
        #50000;
        n_errors++;
        tally_and_finish;
    end

    initial begin
        seed = 98933;
        rst_n_i = 1'b0;
        seq_wr = 1'b0;
        seq_addr = 12'h000;
        seq_wd = 16'h0000;
        hit = 2'h0;
        n_errors = 0;
        comparisons = 0;
        repeat (8) @(posedge clock_i);
        check("reset flags", {14'h0, f1n, f2n}, 16'h0003);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            adr[i] = (i == 0) ? 12'h000 : (i == 1) ? 12'hfff : 12'($random(seed));
            wr(adr[i], 16'($random(seed)), 2'h3);
        end
        for (int i = 0; i < 8; i++) rd(adr[i]);
        wr(adr[2], 16'($random(seed)), 2'h1);
        rd(adr[2]);
        wr(adr[2], 16'($random(seed)), 2'h2);
        rd(adr[2]);
        host_model_i.go(1'b1, 1'b1, 1'b0, 2'h3, adr[3], ~mem[adr[3]]);
        host_model_i.go(1'b0, 1'b1, 1'b0, 2'h0, adr[4], ~mem[adr[4]]);
        rd(adr[3]);
        rd(adr[4]);
        idle;
        @(posedge clock_i);
        seq_wr <= 1'b1;
        seq_addr <= adr[5];
        seq_wd <= 16'($random(seed));
        @(posedge clock_i);
        seq_wr <= 1'b0;
        mem[adr[5]] = seq_wd;
        seq_addr <= adr[0];
        rd(adr[5]);
        idle;
        #1;
        check("sequential read", srd, mem[adr[0]]);
        for (int o = 0; o < 4; o++) begin
            v[o] = 12'($random(seed));
            reg_op(1'b0, 3'(o), {4'h0, v[o]});
        end
        for (int o = 0; o < 4; o++) reg_op(1'b1, 3'(o), {4'h0, v[o]});
        reg_op(1'b0, 3'h6, 16'h1fff);
        reg_op(1'b1, 3'h6, 16'h0000);
        reg_op(1'b1, 3'h7, 16'h0000);
        idle;
        #1;
        for (int o = 0; o < 4; o++) check("bound", {4'h0, bnd[47-12*o -: 12]}, {4'h0, v[o]});
        @(posedge clock_i);
        hit <= 2'h3;
        @(posedge clock_i);
        hit <= 2'h0;
        reg_op(1'b0, 3'h4, 16'h0000);
        reg_op(1'b1, 3'h4, 16'h0003);
        reg_op(1'b0, 3'h5, 16'h0002);
        idle;
        #1;
        check("flags after clear one", {14'h0, f1n, f2n}, 16'h0002);
        reg_op(1'b0, 3'h5, 16'h0000);
        idle;
        #1;
        check("flags after clear two", {14'h0, f1n, f2n}, 16'h0003);
        idle;
        idle;
        check("pending reads", 16'(exp_q.size()), 16'h0000);
        tally_and_finish;
    end
endmodule
